/* hw/uvf_top.sv */
// Input-low supervision and fault response sequencer
//
// Overview of operation
// RULE_01: A 16-bit warning limit at code 0x58 is stored and also serves as the ratio threshold.
// RULE_02: The ratio function acts only while the vendor feature option enables it.
// RULE_03: A 16-bit fault limit at code 0x59 is stored and an input below it raises the fault.
// RULE_04: Response 00 keeps the output running through a fault.
// RULE_05: Response 01 keeps running for the programmed delay.
// RULE_06: Response 01 with the fault still present after the delay follows the retry field.
// RULE_07: Response 10 turns the output off at once and then follows the retry field.
// RULE_08: Response 11 keeps the output off until a clear, reset or off-then-on command; the code also leaves the latch on any write of the response byte.
// RULE_09: Retry field 000 never restarts and stays off until cleared.
// RULE_10: Retry field 001 to 110 allows that many restart attempts.
// RULE_11: After the last failed attempt the output stays off until cleared.
// RULE_12: Attempts start one programmed delay apart.
// RULE_13: Retry field 111 retries without limit until commanded off or another fault stops it.
// RULE_14: The delay field gives a count of time units with 0 meaning one unit.
// RULE_15: Delay codes 0 to 7 mean 1 to 128 units of a separately supplied unit length.
// RULE_16: A clear or a new response byte resets the attempt counter and the timer.
`include "uvf_map.svh"
`default_nettype none
module uvf_top
(
	// Clock and reset
	input  wire logic               clock_i,
	input  wire logic               sys_rst_i,
	// Command port
	input  wire logic [7:0]         cmd_code_i,
	input  wire logic               cmd_wr_i,
	input  wire logic               cmd_rd_i,
	input  wire uvf_pkg::uvf_word_t cmd_wdata_i,
	output logic [15:0]             cmd_rdata_o,
	output logic                    cmd_rvalid_o,
	// Input voltage sample
	input  wire uvf_pkg::uvf_word_t vin_sample_i,
	input  wire logic               vin_valid_i,
	// Control and clear sources
	input  wire logic               operation_on_i,
	input  wire logic               ratio_opt_enable_i,
	input  wire logic [15:0]        unit_cycles_i,
	input  wire logic               clear_status_i,
	input  wire logic               clear_faults_i,
	input  wire logic               other_fault_i,
	// Status and power stage control
	output logic                    output_enable_o,
	output logic                    uv_warn_o,
	output logic                    uv_fault_o,
	output logic                    ratio_reg_active_o,
	output logic                    latched_off_o,
	output logic [2:0]              retry_count_o
);
	import uvf_pkg::*;

	uvf_word_t  warn_limit_r;
	uvf_word_t  fault_limit_r;
	logic [7:0] action_r;
	uvf_state_t state_r;
	logic [2:0] tries_r;
	logic       start_r;
	logic       abort_r;
	logic       below_warn;
	logic       below_fault;
	logic       ratio_active;
	logic       action_wr;
	logic       clear_any;
	logic       fault_rise;
	logic       fault_seen_r;
	uvf_resp_t  resp;
	logic [2:0] retry_set;
	logic [2:0] tries_nxt;
	logic       tries_spent;

	uvf_timer_if tif ();

	// Field decode
	assign resp      = uvf_resp_t'(action_r[`UVF_RESP_HI:`UVF_RESP_LO]);
	assign retry_set = action_r[`UVF_RETRY_HI:`UVF_RETRY_LO];
	assign action_wr = cmd_wr_i && (cmd_code_i == `UVF_CMD_ACTION);
	assign clear_any = clear_status_i || clear_faults_i; // RULE_08
	// Edge detect: a standing fault flags once
	assign fault_rise = below_fault && !fault_seen_r;
	assign tries_nxt = tries_r + 3'h1;
	// Continuous retry never spends attempts, so its count stays zero
	assign tries_spent = (retry_set != `UVF_RETRY_FOREVER) && (tries_nxt >= retry_set); // RULE_10 RULE_13

	assign tif.start       = start_r;
	assign tif.abort       = abort_r;
	assign tif.code        = action_r[`UVF_DELAY_HI:`UVF_DELAY_LO]; // RULE_14
	// Unit length comes from outside; zero acts as one clock
	assign tif.unit_cycles = unit_cycles_i; // RULE_15

	uvf_cmp u_cmp
	(
		.clock_i            (clock_i),
		.sys_rst_i          (sys_rst_i),
		.vin_sample_i       (vin_sample_i),
		.vin_valid_i        (vin_valid_i),
		.warn_limit_i       (warn_limit_r),
		.fault_limit_i      (fault_limit_r),
		.ratio_opt_enable_i (ratio_opt_enable_i),
		.below_warn_o       (below_warn),
		.below_fault_o      (below_fault),
		.ratio_active_o     (ratio_active)
	);

	uvf_timer u_timer
	(
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.tif       (tif)
	);

	// Limit and action registers
	// Writes to other codes fall through untouched
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			warn_limit_r  <= `UVF_WARN_RST;
			fault_limit_r <= `UVF_FAULT_RST;
			action_r      <= `UVF_ACTION_RST;
		end
		else if (cmd_wr_i)
		begin
			if (cmd_code_i == `UVF_CMD_WARN)
				warn_limit_r <= cmd_wdata_i; // RULE_01
			if (cmd_code_i == `UVF_CMD_FAULT)
				fault_limit_r <= cmd_wdata_i; // RULE_03
			if (cmd_code_i == `UVF_CMD_ACTION)
				action_r <= cmd_wdata_i[7:0];
		end
	end

	// Read answers one cycle later; unknown codes read zero
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cmd_rdata_o  <= 16'h0000;
			cmd_rvalid_o <= 1'b0;
		end
		else
		begin
			cmd_rvalid_o <= cmd_rd_i;
			if (cmd_rd_i)
			begin
				case (cmd_code_i)
					`UVF_CMD_WARN:   cmd_rdata_o <= warn_limit_r;
					`UVF_CMD_FAULT:  cmd_rdata_o <= fault_limit_r;
					`UVF_CMD_ACTION: cmd_rdata_o <= {8'h00, action_r};
					default:         cmd_rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// Sticky fault status; a new fault beats a clear in the same cycle
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			uv_fault_o   <= 1'b0;
			fault_seen_r <= 1'b0;
		end
		else
		begin
			fault_seen_r <= below_fault;
			if (fault_rise)
				uv_fault_o <= 1'b1; // RULE_03
			else if (clear_any)
				uv_fault_o <= 1'b0; // RULE_08
		end
	end

	// Response sequencer
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= ST_RUN;
			tries_r <= 3'h0;
			start_r <= 1'b0;
			abort_r <= 1'b0;
		end
		else
		begin
			start_r <= 1'b0;
			abort_r <= 1'b0;
			if (!operation_on_i || clear_any || action_wr)
			begin
				// Off command, clear or new action restarts from scratch
				state_r <= ST_RUN; // RULE_08 RULE_13
				tries_r <= 3'h0; // RULE_16
				abort_r <= 1'b1; // RULE_16
			end
			else
			begin
				case (state_r)
					ST_RUN:
					begin
						if (below_fault)
						begin
							case (resp)
								RESP_IGNORE:
									state_r <= ST_RUN; // RULE_04
								RESP_GRACE:
								begin
									state_r <= ST_GRACE; // RULE_05
									start_r <= 1'b1; // RULE_05
								end
								RESP_RETRY:
								begin
									if (retry_set == `UVF_RETRY_NONE)
										state_r <= ST_LATCH; // RULE_09
									else
									begin
										state_r <= ST_WAIT; // RULE_07
										start_r <= 1'b1; // RULE_12
									end
								end
								default:
									state_r <= ST_LATCH; // RULE_08
							endcase
						end
					end
					ST_GRACE:
					begin
						if (tif.done)
						begin
							if (!below_fault)
								state_r <= ST_RUN;
							else if (retry_set == `UVF_RETRY_NONE)
								state_r <= ST_LATCH; // RULE_06 RULE_09
							else
							begin
								state_r <= ST_WAIT; // RULE_06
								start_r <= 1'b1; // RULE_12
							end
						end
						// Rearm an idle timer rather than hang here
						else if (!tif.busy && !start_r)
							start_r <= 1'b1; // RULE_12
					end
					ST_WAIT:
					begin
						if (other_fault_i)
							state_r <= ST_LATCH; // RULE_13
						else if (tif.done)
						begin
							// Attempt succeeds only with the input no longer below the limit
							if (!below_fault)
							begin
								state_r <= ST_RUN;
								tries_r <= 3'h0;
							end
							else if (tries_spent)
							begin
								state_r <= ST_LATCH; // RULE_11
								tries_r <= tries_nxt; // RULE_10
							end
							else
							begin
								if (retry_set != `UVF_RETRY_FOREVER)
									tries_r <= tries_nxt; // RULE_10
								start_r <= 1'b1; // RULE_12 RULE_13
							end
						end
						else if (!tif.busy && !start_r)
							start_r <= 1'b1; // RULE_12
					end
					ST_LATCH:
						// Left only by reset or the off, clear or new-action branch
						state_r <= ST_LATCH; // RULE_08 RULE_11
					default:
						state_r <= ST_RUN;
				endcase
			end
		end
	end

	// Power stage enable and status pins
	// Another fault cuts the enable at once, whatever the state
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			output_enable_o    <= 1'b0;
			uv_warn_o          <= 1'b0;
			ratio_reg_active_o <= 1'b0;
			latched_off_o      <= 1'b0;
			retry_count_o      <= 3'h0;
		end
		else
		begin
			output_enable_o    <= operation_on_i && !other_fault_i &&
				((state_r == ST_RUN) || (state_r == ST_GRACE)); // RULE_04 RULE_05 RULE_07
			uv_warn_o          <= below_warn;
			ratio_reg_active_o <= ratio_active; // RULE_02
			latched_off_o      <= (state_r == ST_LATCH); // RULE_11
			retry_count_o      <= tries_r;
		end
	end
endmodule
`default_nettype wire

/* hw/uvf_map.svh */
// Command codes, field positions and reset values of the input-low fault block
`ifndef UVF_MAP_SVH
`define UVF_MAP_SVH

`define UVF_CMD_WARN       8'h58
`define UVF_CMD_FAULT      8'h59
`define UVF_CMD_ACTION     8'h5a

`define UVF_RESP_HI        7
`define UVF_RESP_LO        6
`define UVF_RETRY_HI       5
`define UVF_RETRY_LO       3
`define UVF_DELAY_HI       2
`define UVF_DELAY_LO       0

`define UVF_RETRY_NONE     3'h0
`define UVF_RETRY_FOREVER  3'h7

`define UVF_WARN_RST       16'h0000
`define UVF_FAULT_RST      16'h0000
`define UVF_ACTION_RST     8'hc0

`define UVF_UNITS_ONE      8'h01
`define UVF_UNIT_CYC_MIN   16'h0001

`endif

/* hw/uvf_pkg.sv */
// Types shared by the input-low fault block
`default_nettype none
package uvf_pkg;

	typedef enum logic [1:0]
	{
		RESP_IGNORE  = 2'b00,
		RESP_GRACE   = 2'b01,
		RESP_RETRY   = 2'b10,
		RESP_LATCH   = 2'b11
	} uvf_resp_t;

	typedef enum logic [1:0]
	{
		ST_RUN   = 2'b00,
		ST_GRACE = 2'b01,
		ST_WAIT  = 2'b10,
		ST_LATCH = 2'b11
	} uvf_state_t;

	typedef logic [15:0] uvf_word_t;

endpackage
`default_nettype wire

/* hw/uvf_timer_if.sv */
// Carrier between the fault sequencer and its delay timer
`default_nettype none
interface uvf_timer_if;
	logic        start;
	logic        abort;
	logic [2:0]  code;
	logic [15:0] unit_cycles;
	logic        busy;
	logic        done;

	modport ctrl
	(
		output start,
		output abort,
		output code,
		output unit_cycles,
		input  busy,
		input  done
	);

	modport tmr
	(
		input  start,
		input  abort,
		input  code,
		input  unit_cycles,
		output busy,
		output done
	);
endinterface
`default_nettype wire

/* hw/uvf_cmp.sv */
// Threshold comparators for the input-low warning and fault
`include "uvf_map.svh"
`default_nettype none
module uvf_cmp
(
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	// Input sample and limits
	input  wire uvf_pkg::uvf_word_t vin_sample_i,
	input  wire logic             vin_valid_i,
	input  wire uvf_pkg::uvf_word_t warn_limit_i,
	input  wire uvf_pkg::uvf_word_t fault_limit_i,
	input  wire logic             ratio_opt_enable_i,
	// Results
	output logic                  below_warn_o,
	output logic                  below_fault_o,
	output logic                  ratio_active_o
);
	import uvf_pkg::*;

	// Results hold between samples
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			below_warn_o  <= 1'b0;
			below_fault_o <= 1'b0;
		end
		else if (vin_valid_i)
		begin
			below_warn_o  <= (vin_sample_i < warn_limit_i); // RULE_01
			below_fault_o <= (vin_sample_i < fault_limit_i); // RULE_03
		end
	end

	// Same warning compare drives the ratio function
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ratio_active_o <= 1'b0;
		else if (vin_valid_i)
			ratio_active_o <= ratio_opt_enable_i && (vin_sample_i < warn_limit_i); // RULE_02
		else if (!ratio_opt_enable_i)
			ratio_active_o <= 1'b0; // RULE_02
	end
endmodule
`default_nettype wire

/* hw/uvf_timer.sv */
// Delay timer counting 2**code time units
`include "uvf_map.svh"
`default_nettype none
module uvf_timer
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	// Control side
	uvf_timer_if.tmr  tif
);
	import uvf_pkg::*;

	logic [15:0] pre_r;
	logic [7:0]  units_r;
	logic        busy_r;
	logic        done_r;
	logic [15:0] unit_len;

	// A zero unit length would wrap to the longest unit, 65536 clocks
	assign unit_len = (tif.unit_cycles == 16'h0000) ? `UVF_UNIT_CYC_MIN : tif.unit_cycles;
	assign tif.busy = busy_r;
	assign tif.done = done_r;

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pre_r   <= 16'h0000;
			units_r <= 8'h00;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (tif.abort)
				busy_r <= 1'b0; // RULE_16
			else if (tif.start)
			begin
				busy_r  <= 1'b1;
				pre_r   <= unit_len - 16'h0001;
				units_r <= `UVF_UNITS_ONE << tif.code; // RULE_14 RULE_15
			end
			else if (busy_r)
			begin
				if (pre_r != 16'h0000)
					pre_r <= pre_r - 16'h0001;
				else if (units_r == `UVF_UNITS_ONE)
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
				else
				begin
					pre_r   <= unit_len - 16'h0001;
					units_r <= units_r - 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* bench/uvf_monitor.sv */
// Port-level checks of the input-low fault block
`default_nettype none
module uvf_monitor
(
	// Clock and reset
	input wire logic               clock_i,
	input wire logic               sys_rst_i,
	// Command port
	input wire logic [7:0]         cmd_code_i,
	input wire logic               cmd_wr_i,
	input wire logic               cmd_rd_i,
	input wire uvf_pkg::uvf_word_t cmd_wdata_i,
	input wire logic [15:0]        cmd_rdata_o,
	input wire logic               cmd_rvalid_o,
	// Sample and controls
	input wire uvf_pkg::uvf_word_t vin_sample_i,
	input wire logic               vin_valid_i,
	input wire logic               operation_on_i,
	input wire logic               ratio_opt_enable_i,
	input wire logic               clear_status_i,
	input wire logic               clear_faults_i,
	input wire logic               other_fault_i,
	// Status
	input wire logic               output_enable_o,
	input wire logic               uv_fault_o,
	input wire logic               ratio_reg_active_o,
	input wire logic               latched_off_o,
	input wire logic [2:0]         retry_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// Shadow of the fault limit, so detection is judged against the live value
	logic [15:0] flim_r;
	always_ff @(posedge clock_i or posedge sys_rst_i)
		if (sys_rst_i)
			flim_r <= 16'h0000;
		else if (cmd_wr_i && cmd_code_i == 8'h59)
			flim_r <= cmd_wdata_i;
	a_read_answer: assert property (cmd_rd_i |=> cmd_rvalid_o)
		else $error("read not answered");
	a_read_cause: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
		else $error("answer without read");
	a_fault_readback: assert property (cmd_rd_i && cmd_code_i == 8'h59 |=> cmd_rdata_o == $past(flim_r))
		else $error("fault limit readback wrong");
	// Only a fresh drop below the limit; a clear during a standing fault is not re-flagged
	a_fault_detect: assert property ($past(vin_sample_i) >= flim_r && vin_valid_i &&
		vin_sample_i < flim_r && !cmd_wr_i |-> ##2 uv_fault_o)
		else $error("fault not flagged");
	a_ratio_gated: assert property ((!ratio_opt_enable_i)[*3] |-> !ratio_reg_active_o)
		else $error("ratio active while disabled");
	a_off_disables: assert property (!operation_on_i |=> !output_enable_o)
		else $error("output on while commanded off");
	a_latch_holds_off: assert property (latched_off_o && $past(latched_off_o) |-> !output_enable_o)
		else $error("output on while latched");
	a_count_bound: assert property (retry_count_o <= 3'h6)
		else $error("attempt count too high");
	a_clear_restarts: assert property (clear_faults_i || clear_status_i |-> ##2
		retry_count_o == 3'h0 && !latched_off_o)
		else $error("clear did not restart");
	a_drop_cause: assert property ($fell(output_enable_o) |-> uv_fault_o ||
		!$past(operation_on_i) || $past(other_fault_i))
		else $error("output dropped without cause");
	c_latched: cover property (latched_off_o);
	c_dropped: cover property ($fell(output_enable_o));
	c_six_tries: cover property (retry_count_o == 3'h6);
endmodule
`default_nettype wire

/* bench/uvf_host_model.sv */
// Command-issuing host in front of the input-low fault block
`default_nettype none
module uvf_host_model
(
	// Clock
	input  wire logic        clock_i,
	// Command port
	output logic [7:0]       cmd_code_o,
	output logic             cmd_wr_o,
	output logic             cmd_rd_o,
	output logic [15:0]      cmd_wdata_o,
	input  wire logic [15:0] cmd_rdata_i,
	input  wire logic        cmd_rvalid_i,
	// Fault clearing command
	output logic             clear_faults_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		cmd_code_o = 8'h00;
		cmd_wr_o = 1'b0;
		cmd_rd_o = 1'b0;
		cmd_wdata_o = 16'h0000;
		clear_faults_o = 1'b0;
	end
	// Idle cycle after each strobe so no strobe toggles twice at one instant
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		cmd_code_o = code;
		cmd_wdata_o = data;
		cmd_wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		cmd_wr_o = 1'b0;
		cmd_wdata_o = ~data;
		@(posedge clock_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] code, output logic [15:0] data);
		cmd_code_o = code;
		cmd_rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		cmd_rd_o = 1'b0;
		data = cmd_rvalid_i ? cmd_rdata_i : 16'hxxxx;
		@(posedge clock_i);
		#1;
	endtask
	task automatic clr;
		clear_faults_o = 1'b1;
		@(posedge clock_i);
		#1;
		clear_faults_o = 1'b0;
		@(posedge clock_i);
		#1;
	endtask
endmodule
`default_nettype wire

/* bench/uvf_top_tb_top.sv */
// Self-checking bench of the input-low fault block
`default_nettype none
`define CHK(a, e) \
	begin \
		samples_checked++; \
		if ((a) !== (e)) \
		begin \
			fail_count++; \
			$display("unexpected at %0t: got %h want %h", $time, (a), (e)); \
		end \
	end
module uvf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_i, sys_rst_i, wr, rd, rv, vv, op, ren, cst, cfl, oth;
	logic        oe, warn, flt, rat, lat;
	logic [7:0]  code;
	logic [15:0] wd, rdat, vin, unit;
	logic [2:0]  cnt;
	int          fail_count, samples_checked;
	uvf_top i_uvf_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_code_i(code),
		.cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_wdata_i(wd), .cmd_rdata_o(rdat),
		.cmd_rvalid_o(rv), .vin_sample_i(vin), .vin_valid_i(vv), .operation_on_i(op),
		.ratio_opt_enable_i(ren), .unit_cycles_i(unit), .clear_status_i(cst),
		.clear_faults_i(cfl), .other_fault_i(oth), .output_enable_o(oe), .uv_warn_o(warn),
		.uv_fault_o(flt), .ratio_reg_active_o(rat), .latched_off_o(lat), .retry_count_o(cnt));
	uvf_host_model i_uvf_host_model (.clock_i(clock_i), .cmd_code_o(code), .cmd_wr_o(wr),
		.cmd_rd_o(rd), .cmd_wdata_o(wd), .cmd_rdata_i(rdat), .cmd_rvalid_i(rv),
		.clear_faults_o(cfl));
	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	task automatic final_report;
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wa(input logic [7:0] a);
		i_uvf_host_model.wr(8'h5a, {8'hab, a});
	endtask
	task automatic calm;
		vin = 16'hffff;
		cyc(4);
		i_uvf_host_model.clr();
	endtask
	task automatic wait_latch;
		int i;
		for (i = 0; i < 400 && lat !== 1'b1; i++)
			cyc(1);
		if (i == 400)
		begin
			fail_count++;
			final_report();
		end
	endtask
	task automatic t_regs;
		logic [15:0] d;
		i_uvf_host_model.rd(8'h5a, d);
		`CHK(d, 16'h00c0)
		i_uvf_host_model.wr(8'h58, 16'h1234);
		i_uvf_host_model.wr(8'h59, 16'h0200);
		wa(8'h12);
		i_uvf_host_model.rd(8'h58, d);
		`CHK(d, 16'h1234)
		i_uvf_host_model.rd(8'h59, d);
		`CHK(d, 16'h0200)
		i_uvf_host_model.rd(8'h5a, d);
		`CHK(d, 16'h0012)
		i_uvf_host_model.rd(8'h5b, d);
		`CHK(d, 16'h0000)
	endtask
	task automatic t_ratio;
		vin = 16'h1000;
		cyc(5);
		`CHK(warn, 1'b1)
		`CHK(rat, 1'b0)
		ren = 1'b1;
		cyc(3);
		`CHK(rat, 1'b1)
		ren = 1'b0;
		vin = 16'hffff;
		cyc(3);
		// Samples are held while the valid strobe is low
		vv = 1'b0;
		vin = 16'h0000;
		cyc(4);
		`CHK(warn, 1'b0)
		`CHK(flt, 1'b0)
		vin = 16'hffff;
		vv = 1'b1;
		cyc(2);
	endtask
	task automatic t_modes;
		wa(8'h00);
		vin = 16'h0000;
		cyc(20);
		`CHK(flt, 1'b1)
		`CHK(oe, 1'b1)
		calm();
		wa(8'hc0);
		vin = 16'h0000;
		cyc(5);
		vin = 16'hffff;
		cyc(30);
		`CHK(oe, 1'b0)
		cst = 1'b1;
		cyc(1);
		cst = 1'b0;
		cyc(2);
		`CHK(oe, 1'b1)
		vin = 16'h0000;
		cyc(5);
		vin = 16'hffff;
		cyc(4);
		`CHK(lat, 1'b1)
		op = 1'b0;
		cyc(1);
		op = 1'b1;
		cyc(2);
		`CHK(oe, 1'b1)
	endtask
	task automatic t_retry;
		for (int n = 0; n < 7; n++)
		begin
			wa({2'b10, n[2:0], 3'h0});
			vin = 16'h0000;
			wait_latch();
			`CHK(oe, 1'b0)
			`CHK(cnt, n[2:0])
			calm();
		end
		// Input recovers during the first wait, so the restart succeeds
		wa(8'h90);
		vin = 16'h0000;
		cyc(4);
		`CHK(oe, 1'b0)
		vin = 16'hffff;
		cyc(6);
		`CHK(oe, 1'b1)
		`CHK(lat, 1'b0)
		calm();
		wa(8'hb8);
		vin = 16'h0000;
		cyc(300);
		`CHK(lat, 1'b0)
		oth = 1'b1;
		wait_latch();
		oth = 1'b0;
		calm();
	endtask
	task automatic t_grace;
		int k;
		int n;
		for (int c = 0; c < 9; c++)
		begin
			// Last pass: code 0 with a zero unit length, which acts as one clock
			unit = (c == 8) ? 16'h0000 : 16'h0002;
			n = (c == 8) ? 1 : 2 * (1 << c);
			wa({5'b01000, c[2:0]});
			vin = 16'h0000;
			for (k = 0; k < 600 && oe === 1'b1; k++)
				cyc(1);
			if (k == 600)
			begin
				fail_count++;
				final_report();
			end
			`CHK(k >= n + 4 && k <= n + 6, 1'b1)
			cyc(2);
			`CHK(lat, 1'b1)
			calm();
		end
		unit = 16'h0002;
		// Grace that ends in one failed attempt
		wa(8'h48);
		vin = 16'h0000;
		wait_latch();
		`CHK(cnt, 3'h1)
		calm();
	endtask
	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		sys_rst_i = 1'b1;
		vin = 16'hffff;
		vv = 1'b1;
		op = 1'b1;
		ren = 1'b0;
		unit = 16'h0002;
		cst = 1'b0;
		oth = 1'b0;
		repeat (20) @(posedge clock_i);
		#1;
		sys_rst_i = 1'b0;
		cyc(2);
		`CHK(oe, 1'b1)
		t_regs();
		t_ratio();
		t_modes();
		t_retry();
		t_grace();
		final_report();
	end
endmodule
bind uvf_top uvf_monitor i_uvf_monitor
(
	.clock_i            (clock_i),
	.sys_rst_i          (sys_rst_i),
	.cmd_code_i         (cmd_code_i),
	.cmd_wr_i           (cmd_wr_i),
	.cmd_rd_i           (cmd_rd_i),
	.cmd_wdata_i        (cmd_wdata_i),
	.cmd_rdata_o        (cmd_rdata_o),
	.cmd_rvalid_o       (cmd_rvalid_o),
	.vin_sample_i       (vin_sample_i),
	.vin_valid_i        (vin_valid_i),
	.operation_on_i     (operation_on_i),
	.ratio_opt_enable_i (ratio_opt_enable_i),
	.clear_status_i     (clear_status_i),
	.clear_faults_i     (clear_faults_i),
	.other_fault_i      (other_fault_i),
	.output_enable_o    (output_enable_o),
	.uv_fault_o         (uv_fault_o),
	.ratio_reg_active_o (ratio_reg_active_o),
	.latched_off_o      (latched_off_o),
	.retry_count_o      (retry_count_o)
);
`default_nettype wire
